// ===== common/sdf_pkg.sv
// Purpose: shared constants for the three-channel sinc decimation filter
// Assumes: core_clk is the master clock; the modulator runs at half its rate
// Notes:   all widths sized for the largest ratio of 16384
//
// How it works
// R1: after reset every channel starts on the fast first-order sinc path
// R2: after two conversions a channel moves to sinc3 until the next reset
// R3: ratios 64 to 1024 send the sinc3 result straight to the output
// R4: ratios 2048 and up run sinc3 at 1024, then sinc1 by 2 to 16
// R5: the sinc responses place nulls at each multiple of the output rate
// R6: response repeats at the modulator rate; rates scale with that rate
// R7: enable, mux/gain change or resync restart a channel's settling
// R8: results keep flowing while settling; nothing is gated or marked
// R9: the host discards results read before the settling time expires
// R10: the first data-ready fall after settling carries a settled sample
// R11: direct sinc3 settling is 728, 856, 1112, 1624, 2648 master clocks
// R12: cascade settling is 4696, 8792, 16984, 33368 master clocks
// R13: a three-bit rate field picks the ratio; a turbo bit selects 64
// R14: modulator rate is half the master clock; output rate is that over ratio
// R15: each channel owns its path state and settling counter
package sdf_pkg;

   // channel count and output word
   localparam int SDF_NCH   = 3;
   localparam int SDF_DW    = 24;
   localparam int SDF_CHW   = 2;

   // datapath widths: sinc3 at 1024 needs 3*10+1, sinc1 by 16 adds 4
   localparam int SDF_CICW  = 31;
   localparam int SDF_POSTW = 35;
   localparam int SDF_FASTW = 15;
   localparam int SDF_PHW   = 14;
   localparam int SDF_SETW  = 16;
   localparam int SDF_SHW   = 6;

   // log2 of the ratio: turbo gives 64, the rate field adds to 128
   localparam logic [3:0] SDF_L_TURBO = 4'h6;
   localparam logic [3:0] SDF_L_BASE  = 4'h7;
   localparam logic [3:0] SDF_L_S3MAX = 4'hA;

   // normalised value sits with full scale at this bit
   localparam int SDF_TOP = 34;

   // path switch after this many fast-path conversions
   localparam logic [1:0] SDF_FAST_CONV = 2'h2;

   // output buffer depth
   localparam int SDF_FIFO_DEPTH = 32;

   // settling times in master-clock periods; core_clk is the master clock
   localparam int SDF_CORE_PER_TCLKIN = 1;
   localparam int SDF_SETTLE_64_T   = 728;
   localparam int SDF_SETTLE_128_T  = 856;
   localparam int SDF_SETTLE_256_T  = 1112;
   localparam int SDF_SETTLE_512_T  = 1624;
   localparam int SDF_SETTLE_1024_T = 2648;
   localparam int SDF_SETTLE_X2_T   = 4696;
   localparam int SDF_SETTLE_X4_T   = 8792;
   localparam int SDF_SETTLE_X8_T   = 16984;
   localparam int SDF_SETTLE_X16_T  = 33368;
   localparam int SDF_SETTLE_64   = SDF_SETTLE_64_T * SDF_CORE_PER_TCLKIN;
   localparam int SDF_SETTLE_128  = SDF_SETTLE_128_T * SDF_CORE_PER_TCLKIN;
   localparam int SDF_SETTLE_256  = SDF_SETTLE_256_T * SDF_CORE_PER_TCLKIN;
   localparam int SDF_SETTLE_512  = SDF_SETTLE_512_T * SDF_CORE_PER_TCLKIN;
   localparam int SDF_SETTLE_1024 = SDF_SETTLE_1024_T * SDF_CORE_PER_TCLKIN;

endpackage

// ===== core/sdf_mem.sv
// Purpose: small word store for the output buffer, registered read data
// Assumes: one write and one read port, same clock
// Notes:   a write to the address being read is forwarded to the read data
`timescale 1ns/1ps
module sdf_mem #(
   parameter int WIDTH = 26,
   parameter int DEPTH = 32,
   parameter int AW    = 5
) (
   // clock
   input  wire logic             core_clk,
   // write side
   input  wire logic             we,
   input  wire logic [AW-1:0]    waddr,
   input  wire logic [WIDTH-1:0] wdata,
   // read side
   input  wire logic [AW-1:0]    raddr,
   output logic      [WIDTH-1:0] rdata
);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] cells;
      logic [WIDTH-1:0]            rd;
   } sdf_mem_type;

   sdf_mem_type st;
   sdf_mem_type next_st;

   // write, then read with forwarding so a fresh word is never stale
   always_comb begin
      next_st = st;
      if (we) begin
         next_st.cells[waddr] = wdata;
      end
      next_st.rd = (we && (waddr == raddr)) ? wdata : st.cells[raddr];
   end

   // no reset on the array: contents are don't-care until written
   always_ff @(posedge core_clk) begin
      st <= next_st;
   end

   assign rdata = st.rd;

endmodule

// ===== core/sdf_fifo.sv
// Purpose: first-word-fall-through buffer between filters and reader
// Assumes: reader may stall; producer waits on in_ready
// Notes:   head word comes from the memory's read register
`timescale 1ns/1ps
module sdf_fifo #(
   parameter int WIDTH = 26,
   parameter int DEPTH = 32
) (
   // clock and reset
   input  wire logic             core_clk,
   input  wire logic             sys_rst,
   // fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);

   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0]   count;
   } sdf_fifo_type;

   sdf_fifo_type  st;
   sdf_fifo_type  next_st;
   logic          push;
   logic          pop;
   logic [AW-1:0] rd_addr;

   // honest flags straight from the occupancy count
   assign in_ready  = (st.count != (AW+1)'(DEPTH));
   assign out_valid = (st.count != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign rd_addr   = next_st.rd;

   // pointer and count update
   always_comb begin
      next_st = st;
      if (push) begin
         next_st.wr = (st.wr == AW'(DEPTH - 1)) ? '0 : st.wr + 1'b1;
      end
      if (pop) begin
         next_st.rd = (st.rd == AW'(DEPTH - 1)) ? '0 : st.rd + 1'b1;
      end
      case ({push, pop})
         2'b10:   next_st.count = st.count + 1'b1;
         2'b01:   next_st.count = st.count - 1'b1;
         default: next_st.count = st.count;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // storage; read address looks one step ahead so the head is ready
   sdf_mem #(
      .WIDTH (WIDTH),
      .DEPTH (DEPTH),
      .AW    (AW)
   ) u_mem (
      .core_clk (core_clk),
      .we       (push),
      .waddr    (st.wr),
      .wdata    (in_data),
      .raddr    (rd_addr),
      .rdata    (out_data)
   );

endmodule

// ===== core/sdf_decim_top.sv
// Purpose: three-channel sinc decimation filter with fast-settling start
// Assumes: mod_bit comes from modulator logic on core_clk, no crossing needed
// Notes:   results are unsigned ones-density words, full scale = 0x800000
`timescale 1ns/1ps
module sdf_decim_top
   import sdf_pkg::*;
#(
   parameter int SETTLE_X2  = SDF_SETTLE_X2_T * SDF_CORE_PER_TCLKIN,
   parameter int SETTLE_X4  = SDF_SETTLE_X4_T * SDF_CORE_PER_TCLKIN,
   parameter int SETTLE_X8  = SDF_SETTLE_X8_T * SDF_CORE_PER_TCLKIN,
   parameter int SETTLE_X16 = SDF_SETTLE_X16_T * SDF_CORE_PER_TCLKIN,
   parameter int FIFO_DEPTH = SDF_FIFO_DEPTH
) (
   // clock and reset
   input  wire logic               core_clk,
   input  wire logic               sys_rst,
   // modulator bitstreams, one per channel
   input  wire logic [SDF_NCH-1:0] mod_bit,
   // rate configuration
   input  wire logic [2:0]         rate_select_field,
   input  wire logic               turbo_rate_enable,
   // channel control
   input  wire logic [SDF_NCH-1:0] ch_enable,
   input  wire logic [SDF_NCH-1:0] ch_setting_change,
   input  wire logic               resync,
   // result stream
   output logic                    out_valid,
   input  wire logic               out_ready,
   output logic      [SDF_DW-1:0]  out_data,
   output logic      [SDF_CHW-1:0] out_chan,
   output logic                    data_ready_n,
   // settling timers, informational only
   output logic      [SDF_NCH-1:0] settle_done
);

   // filter arithmetic, cleared as a whole on restart
   typedef struct packed {
      logic [SDF_CICW-1:0]  int1;
      logic [SDF_CICW-1:0]  int2;
      logic [SDF_CICW-1:0]  int3;
      logic [SDF_CICW-1:0]  dly1;
      logic [SDF_CICW-1:0]  dly2;
      logic [SDF_CICW-1:0]  dly3;
      logic [SDF_POSTW-1:0] post;
      logic [SDF_FASTW-1:0] fast;
      logic [SDF_PHW-1:0]   phase;
   } sdf_filt_type;

   // per-channel state; convs survives restarts, only reset clears it
   typedef struct packed {
      sdf_filt_type      filt;
      logic [1:0]        convs;
      logic [SDF_SETW-1:0] settle;
      logic              on;
      logic              pend;
      logic [SDF_DW-1:0] result;
   } sdf_chan_type;

   typedef struct packed {
      sdf_chan_type [SDF_NCH-1:0] ch;
      logic                       mod_phase;
      logic [3:0]                 lsel;
   } sdf_state_type;

   sdf_state_type             st;
   sdf_state_type             next_st;
   logic                      fifo_ready;
   logic                      push;
   logic [SDF_CHW-1:0]        push_ch;
   logic [SDF_DW-1:0]         push_word;
   logic [SDF_DW+SDF_CHW-1:0] fifo_out;

   // log2 of the overall ratio from the rate field and turbo bit
   function automatic logic [3:0] f_total_l(input logic [2:0] rate, input logic turbo);
      f_total_l = turbo ? SDF_L_TURBO : SDF_L_BASE + {1'b0, rate};
   endfunction

   // low-bit mask used to find the last modulator sample of a block
   function automatic logic [SDF_PHW-1:0] f_mask(input logic [3:0] l);
      logic [SDF_PHW:0] one;
      one = (SDF_PHW+1)'(1) << l;
      f_mask = SDF_PHW'(one - 1'b1);
   endfunction

   // settling count for a ratio
   function automatic logic [SDF_SETW-1:0] f_settle(input logic [3:0] l);
      case (l)
         4'h6:    f_settle = SDF_SETW'(SDF_SETTLE_64);
         4'h7:    f_settle = SDF_SETW'(SDF_SETTLE_128);
         4'h8:    f_settle = SDF_SETW'(SDF_SETTLE_256);
         4'h9:    f_settle = SDF_SETW'(SDF_SETTLE_512);
         4'hA:    f_settle = SDF_SETW'(SDF_SETTLE_1024);
         4'hB:    f_settle = SDF_SETW'(SETTLE_X2);
         4'hC:    f_settle = SDF_SETW'(SETTLE_X4);
         4'hD:    f_settle = SDF_SETW'(SETTLE_X8);
         default: f_settle = SDF_SETW'(SETTLE_X16);
      endcase
   endfunction

   // scale a raw sum whose full scale is 2^bits up to the output word
   function automatic logic [SDF_DW-1:0] f_norm(input logic [SDF_POSTW-1:0] v,
                                               input logic [SDF_SHW-1:0] bits);
      logic [SDF_POSTW-1:0] t;
      t = v << (SDF_SHW'(SDF_TOP) - bits);
      f_norm = t[SDF_TOP -: SDF_DW];
   endfunction

   // main filter and control update
   always_comb begin
      logic [3:0]          l_new;
      logic [3:0]          k3;
      logic [SDF_SHW-1:0]  s3_bits;
      logic [SDF_PHW-1:0]  m3;
      logic [SDF_PHW-1:0]  ml;
      logic                cfg_change;
      logic                tick;
      logic                restart;
      logic                found;
      logic [SDF_CICW-1:0] cmb1;
      logic [SDF_CICW-1:0] cmb2;
      logic [SDF_CICW-1:0] cmb3;
      sdf_chan_type        c;
      next_st    = st;
      restart    = 1'b0;
      c          = '0;
      l_new      = f_total_l(rate_select_field, turbo_rate_enable);
      cfg_change = (l_new != st.lsel);
      // R13: ratio from rate field and turbo
      next_st.lsel = l_new;
      // R4: sinc3 capped at 1024, sinc1 takes the rest
      k3      = (st.lsel > SDF_L_S3MAX) ? SDF_L_S3MAX : st.lsel;
      s3_bits = SDF_SHW'(k3) * SDF_SHW'(3) + SDF_SHW'(st.lsel - k3);
      m3      = f_mask(k3);
      ml      = f_mask(st.lsel);
      // R14: modulator sample every second master clock
      tick              = st.mod_phase;
      next_st.mod_phase = ~st.mod_phase;
      // one word per cycle into the buffer, lowest channel first
      found     = 1'b0;
      push_ch   = '0;
      push_word = '0;
      for (int i = 0; i < SDF_NCH; i++) begin
         if (st.ch[i].pend && !found) begin
            found     = 1'b1;
            push_ch   = SDF_CHW'(i);
            push_word = st.ch[i].result;
         end
      end
      push = found;
      cmb1 = '0;
      cmb2 = '0;
      cmb3 = '0;
      // R15: every channel runs on its own copy of the state
      for (int i = 0; i < SDF_NCH; i++) begin
         c = st.ch[i];
         // R7: restart events
         restart = ch_setting_change[i] || resync || cfg_change
                   || (ch_enable[i] && !c.on);
         c.on = ch_enable[i];
         // buffer stall keeps the word pending; a new one would overwrite it
         if (push && fifo_ready && (push_ch == SDF_CHW'(i))) begin
            c.pend = 1'b0;
         end
         if (c.settle != '0) begin
            c.settle = c.settle - 1'b1;
         end
         if (!ch_enable[i] || restart) begin
            c.filt = '0;
            // R11: direct sinc3 settling
            // R12: cascade settling
            if (restart) begin
               c.settle = f_settle(l_new);
            end
         end else if (tick) begin
            // R6: integrators advance at the modulator rate
            c.filt.int1 = c.filt.int1 + SDF_CICW'(mod_bit[i]);
            c.filt.int2 = c.filt.int2 + c.filt.int1;
            c.filt.int3 = c.filt.int3 + c.filt.int2;
            c.filt.fast = c.filt.fast + SDF_FASTW'(mod_bit[i]);
            // R5: comb stage at the sinc3 decimation point
            if ((c.filt.phase & m3) == m3) begin
               cmb1 = c.filt.int3 - c.filt.dly1;
               c.filt.dly1 = c.filt.int3;
               cmb2 = cmb1 - c.filt.dly2;
               c.filt.dly2 = cmb1;
               cmb3 = cmb2 - c.filt.dly3;
               c.filt.dly3 = cmb2;
               // R3: sinc1 stage degenerates to one term up to 1024
               c.filt.post = c.filt.post + SDF_POSTW'(cmb3);
            end
            // end of an output period at the full ratio
            if ((c.filt.phase & ml) == ml) begin
               // R1: fast sinc1 result for the first conversions
               if (c.convs < SDF_FAST_CONV) begin
                  c.result = f_norm(SDF_POSTW'(c.filt.fast), SDF_SHW'(st.lsel));
                  c.convs  = c.convs + 1'b1;
               end else begin
                  // R2: sinc3 path from here until reset
                  c.result = f_norm(c.filt.post, s3_bits);
               end
               // R8: every result is released, settled or not
               c.pend      = 1'b1;
               c.filt.post = '0;
               c.filt.fast = '0;
            end
            c.filt.phase = c.filt.phase + 1'b1;
         end
         next_st.ch[i] = c;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // output buffer; its ready stalls the channel arbiter above
   sdf_fifo #(
      .WIDTH (SDF_DW + SDF_CHW),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .core_clk  (core_clk),
      .sys_rst   (sys_rst),
      .in_valid  (push),
      .in_ready  (fifo_ready),
      .in_data   ({push_ch, push_word}),
      .out_valid (out_valid),
      .out_ready (out_ready),
      .out_data  (fifo_out)
   );

   assign out_data = fifo_out[SDF_DW-1:0];
   assign out_chan = fifo_out[SDF_DW +: SDF_CHW];

   // R10: data-ready falls when a word is shown
   assign data_ready_n = ~out_valid;

   // timers only help the host track settling; data is never held back
   always_comb begin
      for (int i = 0; i < SDF_NCH; i++) begin
         settle_done[i] = st.ch[i].on && (st.ch[i].settle == '0);
      end
   end

endmodule

// ===== test/sdf_far_side.sv
// Purpose: modulator bitstreams and result reader facing the filter
// Assumes: dens gives the ones per eight modulator ticks, per channel
// Notes:   reader pauses gap cycles after each word; hold stalls it
`timescale 1ns/1ps
module sdf_far_side
   import sdf_pkg::*;
(
   // clock and reset
   input  wire logic               core_clk,
   input  wire logic               sys_rst,
   // bench controls
   input  wire logic [11:0]        dens,
   input  wire logic [3:0]         gap,
   input  wire logic               hold,
   // filter side
   output logic      [SDF_NCH-1:0] mod_bit,
   input  wire logic               out_valid,
   output logic                    out_ready
);
   logic [3:0] ph;
   logic [3:0] pause;

   // half rate: pattern steps every second clock, one bit per tick
   always_ff @(posedge core_clk) begin
      ph <= sys_rst ? 4'h0 : ph + 4'h1;
   end

   // period of eight ticks divides every ratio, so each window is exact
   always_comb begin
      for (int i = 0; i < SDF_NCH; i++)
         mod_bit[i] = ({1'b0, ph[3:1]} < dens[4*i+:4]);
   end

   // reader pause after each taken word
   always_ff @(posedge core_clk) begin
      if (sys_rst)
         pause <= 4'h0;
      else if (out_valid && out_ready)
         pause <= gap;
      else if (pause != 4'h0)
         pause <= pause - 4'h1;
   end
   assign out_ready = !hold && (pause == 4'h0);
endmodule

// ===== test/sdf_assertions.sv
// Purpose: concurrent checks on result stream, restarts and settling
// Assumes: bound to the filter top, sees its ports only
// Notes:   exact settle time is watched on channel 0 at the turbo ratio
`timescale 1ns/1ps
module sdf_assertions
   import sdf_pkg::*;
(
   // clock and reset
   input wire logic               core_clk,
   input wire logic               sys_rst,
   // filter inputs
   input wire logic [SDF_NCH-1:0] mod_bit,
   input wire logic [2:0]         rate_select_field,
   input wire logic               turbo_rate_enable,
   input wire logic [SDF_NCH-1:0] ch_enable,
   input wire logic [SDF_NCH-1:0] ch_setting_change,
   input wire logic               resync,
   // result stream
   input wire logic               out_valid,
   input wire logic               out_ready,
   input wire logic [SDF_DW-1:0]  out_data,
   input wire logic [SDF_CHW-1:0] out_chan,
   input wire logic               data_ready_n,
   input wire logic [SDF_NCH-1:0] settle_done
);
   logic [11:0] since;
   logic        dirty;

   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   // cycles since resync; dirty marks any other restart of channel 0
   always_ff @(posedge core_clk) begin
      if (sys_rst || resync) begin
         since <= 12'h000;
         dirty <= sys_rst;
      end else begin
         if (since != 12'hFFF)
            since <= since + 12'h001;
         if (ch_setting_change[0] || $changed({rate_select_field, turbo_rate_enable, ch_enable}))
            dirty <= 1'b1;
      end
   end

   sequence s_stall;
      out_valid && !out_ready;
   endsequence
   sequence s_lone_change;
      ch_setting_change == 3'h2 && !resync && $stable(ch_enable)
         && $stable({rate_select_field, turbo_rate_enable});
   endsequence

   a_data_ready_n_mirror: assert property (data_ready_n == !out_valid)
      else $error("data ready flag disagrees with valid");
   a_head_stands: assert property (s_stall |=> out_valid && $stable(out_data) && $stable(out_chan))
      else $error("stalled head word changed");
   a_reset_quiet: assert property ($fell(sys_rst) |-> !out_valid && settle_done == 3'h0)
      else $error("outputs active right after reset");
   a_resync_all: assert property (resync |=> settle_done == 3'h0)
      else $error("resync left a channel settled");
   // setting change restarts whichever channel was pulsed
   a_change_one: assert property (ch_setting_change != 3'h0 |=> (settle_done & $past(ch_setting_change)) == 3'h0)
      else $error("setting change did not restart its channel");
   a_chan_isolated: assert property (s_lone_change ##0 (settle_done & 3'h5) == 3'h5
      |=> (settle_done & 3'h5) == 3'h5)
      else $error("restart of channel 1 disturbed another channel");
   a_settle_turbo: assert property (turbo_rate_enable && ch_enable[0] && !dirty
      && since >= SDF_SETTLE_64 - 1 && since <= SDF_SETTLE_64
      |-> settle_done[0] == (since == SDF_SETTLE_64))
      else $error("turbo settle time wrong on channel 0");
   a_chan_range: assert property (out_valid |-> out_chan <= 2'h2)
      else $error("result carries a channel that does not exist");
endmodule

bind sdf_decim_top sdf_assertions u_sdf_chk (.core_clk, .sys_rst, .mod_bit,
   .rate_select_field, .turbo_rate_enable, .ch_enable, .ch_setting_change, .resync,
   .out_valid, .out_ready, .out_data, .out_chan, .data_ready_n, .settle_done);

// ===== test/sinc_decimation_filter_test.sv
// Purpose: self-checking bench for the three-channel decimation filter
// Assumes: far-side model makes the bitstreams and takes the results
// Notes:   cascade settle counts shortened by parameter to keep runs short
`timescale 1ns/1ps
module sinc_decimation_filter_test;
   import sdf_pkg::*;

   localparam int X2 = 100;
   localparam int X4 = 200;
   localparam int X8 = 300;
   localparam int X16 = 400;

   logic               core_clk = 1'b0;
   logic               sys_rst = 1'b1;
   logic [2:0]         rate_select_field = 3'h0;
   logic               turbo_rate_enable = 1'b1;
   logic [SDF_NCH-1:0] ch_enable = 3'h7;
   logic [SDF_NCH-1:0] ch_setting_change = 3'h0;
   logic               resync = 1'b0;
   logic [11:0]        dens = 12'h000;
   logic [3:0]         gap = 4'h1;
   logic               hold = 1'b0;
   logic [SDF_NCH-1:0] mod_bit;
   logic               out_valid;
   logic               out_ready;
   logic [SDF_DW-1:0]  out_data;
   logic [SDF_CHW-1:0] out_chan;
   logic               data_ready_n;
   logic [SDF_NCH-1:0] settle_done;
   int num_errors = 0;
   int compares = 0;
   int nconv [3] = '{0, 0, 0};
   int nrst [3] = '{0, 0, 0};
   int unsettled = 0;
   int c, m, n, k;

   sdf_decim_top #(.SETTLE_X2(X2), .SETTLE_X4(X4), .SETTLE_X8(X8), .SETTLE_X16(X16),
      .FIFO_DEPTH(SDF_FIFO_DEPTH)) DUT (.core_clk, .sys_rst, .mod_bit, .rate_select_field,
      .turbo_rate_enable, .ch_enable, .ch_setting_change, .resync, .out_valid, .out_ready,
      .out_data, .out_chan, .data_ready_n, .settle_done);
   sdf_far_side PEER (.core_clk, .sys_rst, .dens, .gap, .hold, .mod_bit, .out_valid,
      .out_ready);

   // 20 MHz master clock
   always #25 core_clk = ~core_clk;

   // expected settle count; mode 8 stands for turbo
   function automatic int settle_of(input int md);
      int t [9] = '{856, 1112, 1624, 2648, X2, X4, X8, X16, 728};
      return t[md];
   endfunction

   function automatic logic [11:0] rnd_dens();
      return {4'($urandom_range(8)), 4'($urandom_range(8)), 4'($urandom_range(8))};
   endfunction

   task automatic tick(input int cnt);
      repeat (cnt) @(posedge core_clk);
      #2;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task give_verdict();
      $display("compares %0d errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic limit(input int cnt, input int lim);
      if (cnt >= lim) begin
         num_errors++;
         $display("Error at %0t: wait ran out", $time);
         give_verdict();
      end
   endtask

   // score popped words; sinc1 start words and late sinc3 words are exact
   // sampled at the falling edge so the values are settled before the pop
   always @(negedge core_clk) begin
      if (!sys_rst && out_valid === 1'b1 && out_ready === 1'b1) begin
         c = int'(out_chan) % 3;
         if (settle_done[c] !== 1'b1)
            unsettled++;
         if (nconv[c] < 2 || nrst[c] >= 5)
            chk(out_data, {dens[4*c+:4], 20'h00000});
         nconv[c]++;
         nrst[c]++;
      end
   end

   initial begin
      void'($urandom(16074));
      dens = rnd_dens();
      tick(12);
      sys_rst = 1'b0;
      // fast start, then ten channel 0 words in 1280 clocks at turbo
      tick(1400);
      gap = 4'h0;
      tick(300);
      n = nconv[0];
      tick(1280);
      chk(nconv[0] - n, 10);
      // every rate code: settle count, then exact words where not too long
      for (m = 0; m < 9; m++) begin
         rate_select_field = 3'(m);
         turbo_rate_enable = (m == 8);
         gap = 4'($urandom_range(3));
         dens = rnd_dens();
         nrst = '{0, 0, 0};
         tick(4);
         resync = 1'b1;
         tick(1);
         resync = 1'b0;
         n = 0;
         while (settle_done[0] !== 1'b1 && n < 3000) begin
            tick(1);
            n++;
         end
         limit(n, 3000);
         chk(n, settle_of(m));
         if (m < 5 || m == 8)
            tick(12 * ((m == 8) ? 64 : (128 << m)));
      end
      // restart one channel, then toggle another's enable
      gap = 4'h0;
      unsettled = 0;
      nrst[1] = 0;
      ch_setting_change = 3'h2;
      tick(1);
      ch_setting_change = 3'h0;
      chk(settle_done, 3'h5);
      nrst[2] = 0;
      ch_enable = 3'h3;
      tick(2);
      ch_enable = 3'h7;
      tick(1);
      chk(settle_done, 3'h1);
      tick(1000);
      chk(unsettled > 0, 1'b1);
      // stall until the buffer is full, then drain it with producers off
      hold = 1'b1;
      tick(1600);
      chk(data_ready_n, 1'b0);
      n = nconv[0] + nconv[1] + nconv[2];
      ch_enable = 3'h0;
      hold = 1'b0;
      k = 0;
      while (out_valid !== 1'b0 && k < 200) begin
         tick(1);
         k++;
      end
      limit(k, 200);
      chk(nconv[0] + nconv[1] + nconv[2] - n >= SDF_FIFO_DEPTH, 1'b1);
      chk(data_ready_n, 1'b1);
      // reset in mid-run brings the fast path back
      // enabling restarts every channel, so its first sinc3 words are unsettled
      nrst = '{0, 0, 0};
      ch_enable = 3'h7;
      tick(300);
      sys_rst = 1'b1;
      tick(2);
      chk(out_valid, 1'b0);
      chk(settle_done, 3'h0);
      nconv = '{0, 0, 0};
      nrst = '{0, 0, 0};
      sys_rst = 1'b0;
      tick(900);
      chk(nconv[2] >= 5, 1'b1);
      give_verdict();
   end
endmodule
